// *** inc/bpcc_regs.vh ***
// register offsets, bit positions, reset values and constants of the blink-phase and setup block
`ifndef BPCC_REGS_VH
`define BPCC_REGS_VH
`define BPCC_ADDR_W 8
`define BPCC_DATA_W 8
`define BPCC_PORTS 16
// register offsets
`define BPCC_OFF_PHASE0_LO 8'h02
`define BPCC_OFF_PHASE0_HI 8'h03
`define BPCC_OFF_PORTDIR_LO 8'h06
`define BPCC_OFF_PORTDIR_HI 8'h07
`define BPCC_OFF_PHASE1_LO 8'h0A
`define BPCC_OFF_PHASE1_HI 8'h0B
`define BPCC_OFF_MASTER_INT 8'h0E
`define BPCC_OFF_SETUP 8'h0F
`define BPCC_OFF_INTENS_FIRST 8'h10
`define BPCC_OFF_INTENS_LAST 8'h17
// setup register bit positions
`define BPCC_BIT_BLINK_EN 0
`define BPCC_BIT_FLIP 1
`define BPCC_BIT_GLOBAL 2
`define BPCC_BIT_IRQ_EN 3
`define BPCC_BIT_AUX0 4
`define BPCC_BIT_AUX1 5
`define BPCC_BIT_PHASE_PIN 6
`define BPCC_BIT_IRQ_STAT 7
// writable field of the setup register (top two bits ignored)
`define BPCC_SETUP_WMASK 8'h3F
// reset values
`define BPCC_RST_SETUP 6'h0C
`define BPCC_RST_PHASE 8'hFF
`define BPCC_RST_PORTDIR 8'hFF
`define BPCC_RST_MASTER 8'h0F
`define BPCC_RST_INTENS 8'hFF
`define BPCC_ZERO_BYTE 8'h00
`endif

// *** rtl/bpcc_sync2.v ***
// two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module bpcc_sync2 (
	// clock and reset
	input wire sys_clk,
	input wire resetn,
	// level in and out
	input wire async_in,
	output reg sync_out
);
	reg meta; // first stage, read only by the second

	// two flops, constant reset values only
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			meta <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule // bpcc_sync2
`default_nettype wire

// *** rtl/bpcc_blink_ctrl.v ***
// setup register, blink phase selection, port and shared pin drive
//
// Summary of operation
// R1: setup bit D0 enables blink mode
// R2: phase is flip bit XOR phase input
// R3: blink off uses phase-0 registers only
// R4: output bit 1 releases pin, 0 pulls low
// R5: D2 picks shared or per-port intensity
// R6: D3 routes shared pin to change interrupt
// R7: blink off: D4 sets shared pin level
// R8: blink on: D4 phase 0, D5 phase 1
// R9: setup read D6 shows phase input level
// R10: D7 reports change; with D3 set, pin low while set
// R11: host may fill phase-1 with ones
// R12: setup write ignores top two bits
// R13: phase input synchronised by two flops
`timescale 1ns/100ps
`default_nettype none
`include "bpcc_regs.vh"
module bpcc_blink_ctrl (
	// clock and reset
	input wire sys_clk,
	input wire resetn,
	// register access from the serial bus slave
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	output reg reg_rvalid,
	// external phase-toggle input pin
	input wire phase_toggle_pin,
	// input change detection from the transition logic
	input wire change_detected,
	// port pins port_pin_first .. port_pin_last, open drain
	output wire [15:0] port_out,
	output wire [15:0] port_oe,
	// shared_irq_output_pin, open drain
	output wire shared_irq_output_pin_out,
	output wire shared_irq_output_pin_oe,
	// intensity selection to the pwm engine
	output reg [63:0] port_intensity,
	output reg [3:0] shared_intensity,
	// current phase, for observation
	output wire active_phase
);
	////////////////////////////////////////////////////////////////////
	// storage
	reg [5:0] setup; // writable setup bits D5..D0
	reg [15:0] phase0_lvl; // phase-0 output levels
	reg [15:0] phase1_lvl; // phase-1 output levels
	reg [15:0] port_dir; // 1 = input, 0 = output
	reg [7:0] master_int; // master and shared-pin intensity
	reg [7:0] intens [0:7]; // per-port intensity pairs
	wire phase_sync; // synchronised phase input
	wire blink_en;
	wire [15:0] sel_lvl;
	wire aux_level_phase0;
	wire aux_level_phase1;
	wire aux_sel;
	wire pin_low;
	wire [7:0] setup_read;
	integer i; // loop index of the reset branch only
	integer j; // loop index of the intensity routing only

	////////////////////////////////////////////////////////////////////
	// phase input crossing; the pin is asynchronous to sys_clk
	bpcc_sync2 u_phase_sync ( // R13
		.sys_clk(sys_clk),
		.resetn(resetn),
		.async_in(phase_toggle_pin),
		.sync_out(phase_sync)
	);

	////////////////////////////////////////////////////////////////////
	// phase selection
	assign blink_en = setup[`BPCC_BIT_BLINK_EN]; // R1
	// with blink off both flip bit and pin are masked out
	assign active_phase = blink_en & (setup[`BPCC_BIT_FLIP] ^ phase_sync); // R2 R3
	assign sel_lvl = active_phase ? phase1_lvl : phase0_lvl; // R2 R3

	////////////////////////////////////////////////////////////////////
	// port drive: bit 0 pulls low, bit 1 releases; inputs never driven
	genvar g;
	generate
		for (g = 0; g < `BPCC_PORTS; g = g + 1) begin : g_port
			assign port_out[g] = 1'b0;
			assign port_oe[g] = ~port_dir[g] & ~sel_lvl[g]; // R4
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// shared pin drive
	assign aux_level_phase0 = setup[`BPCC_BIT_AUX0];
	assign aux_level_phase1 = setup[`BPCC_BIT_AUX1];
	// active_phase is already 0 when blink is off, so D4 alone applies
	assign aux_sel = active_phase ? aux_level_phase1 : aux_level_phase0; // R7 R8
	// interrupt mode pulls low while a change is flagged
	assign pin_low = setup[`BPCC_BIT_IRQ_EN] ? change_detected : ~aux_sel; // R6 R10
	assign shared_irq_output_pin_out = 1'b0;
	assign shared_irq_output_pin_oe = pin_low;

	////////////////////////////////////////////////////////////////////
	// intensity routing
	always @* begin
		// shared pin always takes the master low nibble
		shared_intensity = master_int[3:0]; // R5
		// own index so no variable is driven from two processes
		for (j = 0; j < 8; j = j + 1) begin
			if (setup[`BPCC_BIT_GLOBAL]) begin
				port_intensity[j*8 +: 8] = {master_int[3:0], master_int[3:0]}; // R5
			end else begin
				port_intensity[j*8 +: 8] = intens[j]; // R5
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// register writes
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			setup <= `BPCC_RST_SETUP;
			phase0_lvl <= {`BPCC_RST_PHASE, `BPCC_RST_PHASE};
			phase1_lvl <= {`BPCC_RST_PHASE, `BPCC_RST_PHASE};
			port_dir <= {`BPCC_RST_PORTDIR, `BPCC_RST_PORTDIR};
			master_int <= `BPCC_RST_MASTER;
			for (i = 0; i < 8; i = i + 1) begin
				intens[i] <= `BPCC_RST_INTENS;
			end
		end else if (reg_wr) begin
			if (reg_addr == `BPCC_OFF_SETUP) begin
				// status bits D7 and D6 are read-only
				setup <= reg_wdata[5:0]; // R12
			end else if (reg_addr == `BPCC_OFF_PHASE0_LO) begin
				phase0_lvl[7:0] <= reg_wdata;
			end else if (reg_addr == `BPCC_OFF_PHASE0_HI) begin
				phase0_lvl[15:8] <= reg_wdata;
			end else if (reg_addr == `BPCC_OFF_PHASE1_LO) begin
				phase1_lvl[7:0] <= reg_wdata;
			end else if (reg_addr == `BPCC_OFF_PHASE1_HI) begin
				phase1_lvl[15:8] <= reg_wdata;
			end else if (reg_addr == `BPCC_OFF_PORTDIR_LO) begin
				port_dir[7:0] <= reg_wdata;
			end else if (reg_addr == `BPCC_OFF_PORTDIR_HI) begin
				port_dir[15:8] <= reg_wdata;
			end else if (reg_addr == `BPCC_OFF_MASTER_INT) begin
				master_int <= reg_wdata;
			end else if (reg_addr >= `BPCC_OFF_INTENS_FIRST &&
				reg_addr <= `BPCC_OFF_INTENS_LAST) begin
				intens[reg_addr[2:0]] <= reg_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// read data: live status in D7 and D6
	assign setup_read = {change_detected, phase_sync, setup}; // R9 R10

	// registered read answer, one cycle after the strobe
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= `BPCC_ZERO_BYTE;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				if (reg_addr == `BPCC_OFF_SETUP) begin
					reg_rdata <= setup_read; // R9 R10
				end else if (reg_addr == `BPCC_OFF_PHASE0_LO) begin
					reg_rdata <= phase0_lvl[7:0];
				end else if (reg_addr == `BPCC_OFF_PHASE0_HI) begin
					reg_rdata <= phase0_lvl[15:8];
				end else if (reg_addr == `BPCC_OFF_PHASE1_LO) begin
					reg_rdata <= phase1_lvl[7:0];
				end else if (reg_addr == `BPCC_OFF_PHASE1_HI) begin
					reg_rdata <= phase1_lvl[15:8];
				end else if (reg_addr == `BPCC_OFF_PORTDIR_LO) begin
					reg_rdata <= port_dir[7:0];
				end else if (reg_addr == `BPCC_OFF_PORTDIR_HI) begin
					reg_rdata <= port_dir[15:8];
				end else if (reg_addr == `BPCC_OFF_MASTER_INT) begin
					reg_rdata <= master_int;
				end else if (reg_addr >= `BPCC_OFF_INTENS_FIRST &&
					reg_addr <= `BPCC_OFF_INTENS_LAST) begin
					reg_rdata <= intens[reg_addr[2:0]];
				end else begin
					// unmapped here: reads zero
					reg_rdata <= `BPCC_ZERO_BYTE;
				end
			end
		end
	end
endmodule // bpcc_blink_ctrl
`default_nettype wire

// *** tb/bpcc_blink_chk.sv ***
// port assertions of the blink-phase and setup block
`timescale 1ns/100ps
`default_nettype none
module bpcc_blink_chk (
	// clock, reset, register access
	input wire logic sys_clk, resetn, reg_wr, reg_rd, reg_rvalid,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
	// pins and intensity
	input wire logic phase_toggle_pin, change_detected, active_phase,
	input wire logic shared_irq_output_pin_out, shared_irq_output_pin_oe,
	input wire logic [15:0] port_out,
	input wire logic [63:0] port_intensity,
	input wire logic [3:0] shared_intensity
);
	logic [5:0] s; // shadow of the writable setup bits
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////
	// shadow tracks setup writes; top two bits never stored
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			s <= 6'h0C;
		else if (reg_wr && reg_addr == 8'h0F)
			s <= reg_wdata[5:0];
	end
	drive_low_a: assert property (port_out == 16'h0000 && !shared_irq_output_pin_out)
		else $error("open drain level not low");
	read_valid_a: assert property (reg_rvalid == $past(reg_rd))
		else $error("read valid timing");
	blink_off_a: assert property (!s[0] |-> !active_phase)
		else $error("phase moved with blink off");
	// pin reaches the phase two edges later through the synchroniser
	phase_xor_a: assert property (s[0] |-> active_phase == (s[1] ^ $past(phase_toggle_pin, 2)))
		else $error("phase not flip xor pin");
	irq_route_a: assert property (s[3] |-> shared_irq_output_pin_oe == change_detected)
		else $error("shared pin not change flag");
	aux_level_a: assert property (!s[3] |-> shared_irq_output_pin_oe == !(active_phase ? s[5] : s[4]))
		else $error("shared pin not aux level");
	setup_read_a: assert property (reg_rd && reg_addr == 8'h0F |=>
		reg_rdata == {$past(change_detected), $past(phase_toggle_pin, 3), $past(s)})
		else $error("setup readback wrong");
	global_int_a: assert property (s[2] |-> port_intensity == {16{shared_intensity}})
		else $error("global intensity not applied");
endmodule // bpcc_blink_chk
bind bpcc_blink_ctrl bpcc_blink_chk bpcc_blink_chk_inst (.*);
`default_nettype wire

// *** tb/bpcc_phase_src.sv ***
// far-side phase source: a 64 ns link clock while running, else a level
`timescale 1ns/100ps
`default_nettype none
module bpcc_phase_src (
	input wire logic run,
	input wire logic lvl,
	output logic pin
);
	initial pin = 1'b0;
	// half of a 64 ns period; steps land on falling edges, never on a sampling edge
	always begin
		#32;
		pin = run ? ~pin : lvl;
	end
endmodule // bpcc_phase_src
`default_nettype wire

// *** tb/bpcc_blink_ctrl_tb.sv ***
// self-checking bench of the blink-phase and setup block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; $display("wrong value %s exp %h got %h", n, e, s); end end
module bpcc_blink_ctrl_tb;
	logic sys_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic change_detected = 1'b0, run = 1'b0, lvl = 1'b0, pin, irq_out, irq_oe, ph, rvalid;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, rnd = 8'h54, w;
	logic [15:0] port_out, port_oe, p0, p1;
	logic [63:0] inten;
	logic [3:0] sh_int;
	int fail_count = 0, comparisons = 0, i;
	always #2 sys_clk = ~sys_clk;
	bpcc_blink_ctrl bpcc_blink_ctrl_inst (.sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
		.reg_rvalid(rvalid), .phase_toggle_pin(pin), .change_detected(change_detected),
		.port_out(port_out), .port_oe(port_oe), .shared_irq_output_pin_out(irq_out),
		.shared_irq_output_pin_oe(irq_oe), .port_intensity(inten), .shared_intensity(sh_int),
		.active_phase());
	bpcc_phase_src bpcc_phase_src_inst (.run(run), .lvl(lvl), .pin(pin));
	////////////////////////////////////////////////////////////////
	// random byte source
	function automatic [7:0] lfsr(input [7:0] v);
		lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// single-cycle strobes, driven at the falling edge
	task automatic wr(input [7:0] a, input [7:0] d);
		@(negedge sys_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input [7:0] a, input [7:0] e);
		@(negedge sys_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		`CHK("rvalid", 1'b1, rvalid)
		`CHK("rdata", e, rdata)
	endtask
	task automatic end_of_test;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		resetn = 1'b1;
		rd(8'h0F, 8'h0C);
		rd(8'h20, 8'h00);
		change_detected = 1'b1;
		rd(8'h0F, 8'h8C);
		`CHK("irq_oe", 1'b1, irq_oe)
		change_detected = 1'b0;
		// random patterns; phase 1 high byte all ones as hardware off
		for (i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			{p1, p0} = {p1[7:0], p0, rnd};
		end
		p1[15:8] = 8'hFF;
		for (i = 0; i < 2; i++) begin
			wr(8'h02 + i[7:0], p0[8*i+:8]);
			wr(8'h0A + i[7:0], p1[8*i+:8]);
			wr(8'h06 + i[7:0], 8'h00);
		end
		lvl = 1'b1;
		repeat (16) @(negedge sys_clk);
		`CHK("oe_off", ~p0, port_oe)
		// every flip and pin combination, D5 and D4 opposite, top bits set to be dropped
		for (i = 0; i < 8; i++) begin
			w = {2'b11, i[2], ~i[2], 2'b00, i[1], 1'b1};
			lvl = i[0];
			wr(8'h0F, w);
			repeat (16) @(negedge sys_clk);
			ph = i[1] ^ i[0];
			`CHK("oe_ph", ~(ph ? p1 : p0), port_oe)
			`CHK("irq_ph", ~(ph ? w[5] : w[4]), irq_oe)
			rd(8'h0F, {1'b0, i[0], w[5:0]});
		end
		wr(8'h0F, 8'h02);
		`CHK("irq_lo", 1'b1, irq_oe)
		wr(8'h0F, 8'h10);
		`CHK("irq_hz", 1'b0, irq_oe)
		wr(8'h0E, rnd);
		wr(8'h0F, 8'h04);
		`CHK("glob", {16{rnd[3:0]}}, inten)
		wr(8'h0F, 8'h00);
		wr(8'h10, rnd);
		`CHK("own", rnd, inten[7:0])
		`CHK("shared_int", rnd[3:0], sh_int)
		// free-running phase clock with blink on
		wr(8'h0F, 8'h01);
		run = 1'b1;
		repeat (200) @(negedge sys_clk);
		run = 1'b0;
		end_of_test;
	end
endmodule // bpcc_blink_ctrl_tb
`default_nettype wire
